// ### logic/hpfq_filter.sv
// Purpose: 20 Hz second-order low-cut filter on a 16-bit sample stream
// Assumes: One shared multiplier, five taps per sample, no back-to-back
// Notes:   Output FILTERED_AUDIO_OUT pulses valid six edges after accept
`timescale 1ns/1ps
`default_nettype none

module hpfq_filter (
  input  wire logic        REF_CLK,            // 125 MHz clock
  input  wire logic        RST,                // Async reset, active high
  input  wire logic [1:0]  RATE_SEL,           // Input rate code
  input  wire logic        IN_VALID,           // Sample offered
  input  wire logic [15:0] IN_SAMPLE,          // Signed input sample
  output logic             IN_READY,           // Filter can take a sample
  output logic             OUT_VALID,          // One-cycle output strobe
  output logic [15:0]      FILTERED_AUDIO_OUT  // Signed filtered sample
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    hpfq_pkg::hpfq_state_t              st;
    logic [2:0]                         step;
    logic [1:0]                         rate;
    logic signed [hpfq_pkg::HPFQ_YW-1:0] x0;
    logic signed [hpfq_pkg::HPFQ_YW-1:0] x1;
    logic signed [hpfq_pkg::HPFQ_YW-1:0] x2;
    logic signed [hpfq_pkg::HPFQ_YW-1:0] y1;
    logic signed [hpfq_pkg::HPFQ_YW-1:0] y2;
    logic signed [hpfq_pkg::HPFQ_AW-1:0] acc;
    logic                               out_valid;
    logic [15:0]                        out_sample;
  } hpfq_regs_t;

  hpfq_regs_t                          s_reg;
  hpfq_regs_t                          s_next;
  logic signed [hpfq_pkg::HPFQ_YW-1:0] operand;
  logic signed [hpfq_pkg::HPFQ_CW-1:0] coef;
  logic signed [hpfq_pkg::HPFQ_AW-1:0] acc_sum;
  logic signed [hpfq_pkg::HPFQ_YW-1:0] y_new;
  logic signed [hpfq_pkg::HPFQ_YW-1:0] y_round;
  logic                                in_fire;

  // Saturate a Q20.16 word to a 16-bit sample
  function automatic logic [15:0] hpfq_sat(
    input logic signed [hpfq_pkg::HPFQ_YW-1:0] v);
    logic signed [hpfq_pkg::HPFQ_YW-1:0] q;
    q = v >>> hpfq_pkg::HPFQ_FRAC_Y;
    if (q > 36'sh0_0000_7fff)
      return 16'h7fff;
    else if (q < -36'sh0_0000_8000)
      return 16'h8000;
    else
      return q[15:0];
  endfunction : hpfq_sat

  assign IN_READY           = (s_reg.st == hpfq_pkg::HPFQ_IDLE);
  assign in_fire            = IN_VALID && IN_READY;
  assign OUT_VALID          = s_reg.out_valid;
  assign FILTERED_AUDIO_OUT = s_reg.out_sample;

  // ----------------------------------------------------------------------
  // Tap sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (s_reg.step)                      // [R3]
      hpfq_pkg::HPFQ_TAP_B0: operand = s_reg.x0;
      hpfq_pkg::HPFQ_TAP_B1: operand = s_reg.x1;
      hpfq_pkg::HPFQ_TAP_B2: operand = s_reg.x2;
      hpfq_pkg::HPFQ_TAP_A1: operand = s_reg.y1;
      default:               operand = s_reg.y2;
    endcase
    coef = hpfq_pkg::hpfq_coef(s_reg.rate, s_reg.step);  // [R2] [R4]
  end

  // Feedback taps are summed, not subtracted: signs live in the table
  hpfq_mac u_mac (                                // [R9]
    .acc_in  (s_reg.acc),
    .operand (operand),
    .coef    (coef),
    .acc_out (acc_sum)
  );

  // Back to Q20.16; truncation keeps the recursion bit-steady
  assign y_new   = hpfq_pkg::HPFQ_YW'(s_reg.acc >>> hpfq_pkg::HPFQ_FRAC_C);
  assign y_round = y_new + 36'sh0_0000_8000;

  // One multiplier serves all five taps: area traded for a
  // seven-cycle sample period, far inside any audio rate
  always_comb begin
    s_next           = s_reg;
    s_next.out_valid = 1'b0;
    unique case (s_reg.st)
      hpfq_pkg::HPFQ_IDLE: begin
        if (in_fire) begin
          s_next.st   = hpfq_pkg::HPFQ_MAC;
          s_next.step = hpfq_pkg::HPFQ_TAP_B0;
          s_next.rate = RATE_SEL;                 // [R1]
          s_next.x0   = {{(hpfq_pkg::HPFQ_YW-hpfq_pkg::HPFQ_SW-
                           hpfq_pkg::HPFQ_FRAC_Y){IN_SAMPLE[15]}},
                         IN_SAMPLE, 16'h0000};
          s_next.acc  = '0;
        end
      end
      hpfq_pkg::HPFQ_MAC: begin
        s_next.acc = acc_sum;                     // [R3]
        if (s_reg.step == hpfq_pkg::HPFQ_LAST_TAP)
          s_next.st = hpfq_pkg::HPFQ_WRITE;
        else
          s_next.step = s_reg.step + 3'h1;
      end
      hpfq_pkg::HPFQ_WRITE: begin
        // History survives between samples and frames alike
        s_next.x2         = s_reg.x1;             // [R10]
        s_next.x1         = s_reg.x0;
        s_next.y2         = s_reg.y1;
        s_next.y1         = y_new;                // [R9]
        s_next.out_sample = hpfq_sat(y_round);
        s_next.out_valid  = 1'b1;                 // [R10]
        s_next.st         = hpfq_pkg::HPFQ_IDLE;
      end
      default: begin
        s_next.st = hpfq_pkg::HPFQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST)
      s_reg <= '0;                                // [R10]
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence hpfq_accept_s;
    in_fire;
  endsequence

  sequence hpfq_compute_s;
    (s_reg.st == hpfq_pkg::HPFQ_MAC)[*5] ##1
    (s_reg.st == hpfq_pkg::HPFQ_WRITE && !OUT_VALID) ##1
    (OUT_VALID && IN_READY);
  endsequence

  // Ready stays low for the whole computation of one sample
  sequence hpfq_busy_s;
    (!IN_READY)[*6] ##1 IN_READY;
  endsequence

  AST_RATE_LATCH: assert property (                              // [R1]
    in_fire |=> (s_reg.rate == $past(RATE_SEL)) && !IN_READY
  ) else $error("Rate code not captured at accept");

  AST_LATENCY: assert property (                                 // [R3]
    hpfq_accept_s |=> hpfq_compute_s
  ) else $error("Sample not filtered in five taps plus write");

  AST_B2_EQ_B0: assert property (                                // [R4]
    (s_reg.st == hpfq_pkg::HPFQ_MAC && s_reg.step == 3'h2)
      |-> coef == hpfq_pkg::hpfq_coef(s_reg.rate, 3'h0)
  ) else $error("Third feedforward tap differs from first");

  AST_COEF_8K: assert property (                                 // [R5]
    (s_reg.st == hpfq_pkg::HPFQ_MAC && s_reg.step == 3'h0 &&
     s_reg.rate == hpfq_pkg::HPFQ_RATE_8K) |-> coef == hpfq_pkg::HPFQ_B0_8K
  ) else $error("Wrong first tap at 8 kHz");

  AST_COEF_16K: assert property (                                // [R6]
    (s_reg.st == hpfq_pkg::HPFQ_MAC && s_reg.step == 3'h3 &&
     s_reg.rate == hpfq_pkg::HPFQ_RATE_16K) |-> coef == hpfq_pkg::HPFQ_A1_16K
  ) else $error("Wrong first feedback tap at 16 kHz");

  AST_COEF_32K: assert property (                                // [R7]
    (s_reg.st == hpfq_pkg::HPFQ_MAC && s_reg.step == 3'h4 &&
     s_reg.rate == hpfq_pkg::HPFQ_RATE_32K) |-> coef == hpfq_pkg::HPFQ_A2_32K
  ) else $error("Wrong second feedback tap at 32 kHz");

  AST_COEF_48K: assert property (                                // [R8]
    (s_reg.st == hpfq_pkg::HPFQ_MAC && s_reg.step == 3'h1 &&
     s_reg.rate == hpfq_pkg::HPFQ_RATE_48K) |-> coef == hpfq_pkg::HPFQ_B1_48K
  ) else $error("Wrong middle feedforward tap at 48 kHz");

  AST_FEEDBACK: assert property (                                // [R9]
    OUT_VALID |-> s_reg.y1 ==
      hpfq_pkg::HPFQ_YW'($past(s_reg.acc) >>> hpfq_pkg::HPFQ_FRAC_C)
  ) else $error("Stored output is not the five-tap sum");

  AST_HISTORY: assert property (                                 // [R10]
    OUT_VALID |-> s_reg.y2 == $past(s_reg.y1) &&
                  s_reg.x2 == $past(s_reg.x1) &&
                  s_reg.x1 == $past(s_reg.x0)
  ) else $error("History not shifted on output");

  AST_ONE_OUT: assert property (                                 // [R10]
    OUT_VALID |=> !OUT_VALID
  ) else $error("Output strobe longer than one cycle");

  AST_BUSY: assert property (                                    // [R10]
    hpfq_accept_s |=> hpfq_busy_s
  ) else $error("Filter ready again before its output");

  AST_OUT_HOLD: assert property (                                // [R10]
    !OUT_VALID |-> $stable(FILTERED_AUDIO_OUT)
  ) else $error("Output word changed without a strobe");

  AST_STEP_RANGE: assert property (                              // [R3]
    s_reg.st == hpfq_pkg::HPFQ_MAC |-> s_reg.step <= hpfq_pkg::HPFQ_LAST_TAP
  ) else $error("Tap counter ran past the last tap");

  AST_SAMPLE_LATCH: assert property (                            // [R10]
    in_fire |=> s_reg.x0[hpfq_pkg::HPFQ_FRAC_Y +: hpfq_pkg::HPFQ_SW] ==
                $past(IN_SAMPLE)
  ) else $error("Input sample not captured at accept");

endmodule : hpfq_filter

`default_nettype wire

// ### include/hpfq_pkg.sv
// Purpose: Constants, types and coefficient table of the 20 Hz low-cut biquad
// Assumes: Coefficients held as signed Q2.30, state words as signed Q20.16
// Notes:   Coefficients are rounded to nearest from the decimal figures
//
// What this block does
// R1: Accept 8, 16, 32 or 48 kHz streams
// R2: High-pass corner at 20 Hz, -3 dB
// R3: Second-order recursive section, five taps
// R4: Coefficient set chosen by configured input rate
// R5: Use the 8 kHz coefficient set
// R6: Use the 16 kHz coefficient set
// R7: Use the 32 kHz coefficient set
// R8: Use the 48 kHz coefficient set
// R9: Feedback products added with tabulated signs
// R10: Keep history, clear on reset, one out per in

package hpfq_pkg;

  // ----------------------------------------------------------------------
  // Widths and formats
  // ----------------------------------------------------------------------
  localparam int HPFQ_SW     = 16;  // Sample width
  localparam int HPFQ_YW     = 36;  // History word width, Q20.16
  localparam int HPFQ_CW     = 32;  // Coefficient width, Q2.30
  localparam int HPFQ_AW     = 72;  // Accumulator width, Q.46
  localparam int HPFQ_FRAC_Y = 16;
  localparam int HPFQ_FRAC_C = 30;
  localparam logic [2:0] HPFQ_LAST_TAP = 3'h4;  // Five taps, 0..4

  // ----------------------------------------------------------------------
  // Rate selection codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] HPFQ_RATE_8K  = 2'h0;
  localparam logic [1:0] HPFQ_RATE_16K = 2'h1;
  localparam logic [1:0] HPFQ_RATE_32K = 2'h2;
  localparam logic [1:0] HPFQ_RATE_48K = 2'h3;

  // Tap order: b0*x(n), b1*x(n-1), b2*x(n-2), a1*y(n-1), a2*y(n-2)
  localparam logic [2:0] HPFQ_TAP_B0 = 3'h0;
  localparam logic [2:0] HPFQ_TAP_B1 = 3'h1;
  localparam logic [2:0] HPFQ_TAP_B2 = 3'h2;
  localparam logic [2:0] HPFQ_TAP_A1 = 3'h3;
  localparam logic [2:0] HPFQ_TAP_A2 = 3'h4;

  typedef enum logic [1:0] {HPFQ_IDLE, HPFQ_MAC, HPFQ_WRITE} hpfq_state_t;

  // Elaboration-time conversion, round to nearest
  function automatic logic signed [31:0] hpfq_q30(input real c);
    real s;
    s = c * 1073741824.0;
    return 32'($rtoi(s >= 0.0 ? s + 0.5 : s - 0.5));
  endfunction : hpfq_q30

  // ----------------------------------------------------------------------
  // Coefficient table, corner at 20 Hz for every rate
  // ----------------------------------------------------------------------
  // 8 kHz set [R5]
  localparam logic signed [31:0] HPFQ_B0_8K  = hpfq_q30(0.988954248067140);
  localparam logic signed [31:0] HPFQ_B1_8K  = hpfq_q30(-1.977908496134280);
  localparam logic signed [31:0] HPFQ_A1_8K  = hpfq_q30(1.977786483776764);
  localparam logic signed [31:0] HPFQ_A2_8K  = hpfq_q30(-0.978030508491796);
  // 16 kHz set [R6]
  localparam logic signed [31:0] HPFQ_B0_16K = hpfq_q30(0.994461788958195);
  localparam logic signed [31:0] HPFQ_B1_16K = hpfq_q30(-1.988923577916390);
  localparam logic signed [31:0] HPFQ_A1_16K = hpfq_q30(1.988892905899653);
  localparam logic signed [31:0] HPFQ_A2_16K = hpfq_q30(-0.988954249933127);
  // 32 kHz set [R7]
  localparam logic signed [31:0] HPFQ_B0_32K = hpfq_q30(0.997227049904470);
  localparam logic signed [31:0] HPFQ_B1_32K = hpfq_q30(-1.994454099808940);
  localparam logic signed [31:0] HPFQ_A1_32K = hpfq_q30(1.994446410541927);
  localparam logic signed [31:0] HPFQ_A2_32K = hpfq_q30(-0.994461789075954);
  // 48 kHz set [R8]
  localparam logic signed [31:0] HPFQ_B0_48K = hpfq_q30(0.998150511190452);
  localparam logic signed [31:0] HPFQ_B1_48K = hpfq_q30(-1.996301022380904);
  localparam logic signed [31:0] HPFQ_A1_48K = hpfq_q30(1.996297601769122);
  localparam logic signed [31:0] HPFQ_A2_48K = hpfq_q30(-0.996304442992686);

  // Coefficient for one tap at one rate; b2 equals b0
  function automatic logic signed [31:0] hpfq_coef(input logic [1:0] rate,
                                                   input logic [2:0] tap);
    logic signed [31:0] b0;
    logic signed [31:0] b1;
    logic signed [31:0] a1;
    logic signed [31:0] a2;
    unique case (rate)
      HPFQ_RATE_8K: begin
        b0 = HPFQ_B0_8K;  b1 = HPFQ_B1_8K;  a1 = HPFQ_A1_8K;  a2 = HPFQ_A2_8K;
      end
      HPFQ_RATE_16K: begin
        b0 = HPFQ_B0_16K; b1 = HPFQ_B1_16K; a1 = HPFQ_A1_16K; a2 = HPFQ_A2_16K;
      end
      HPFQ_RATE_32K: begin
        b0 = HPFQ_B0_32K; b1 = HPFQ_B1_32K; a1 = HPFQ_A1_32K; a2 = HPFQ_A2_32K;
      end
      HPFQ_RATE_48K: begin
        b0 = HPFQ_B0_48K; b1 = HPFQ_B1_48K; a1 = HPFQ_A1_48K; a2 = HPFQ_A2_48K;
      end
    endcase
    case (tap)
      HPFQ_TAP_B0: return b0;
      HPFQ_TAP_B1: return b1;
      HPFQ_TAP_B2: return b0;
      HPFQ_TAP_A1: return a1;
      default:     return a2;
    endcase
  endfunction : hpfq_coef

endpackage : hpfq_pkg

// ### logic/hpfq_mac.sv
// Purpose: One multiply-accumulate step of the biquad
// Assumes: Operand Q20.16, coefficient Q2.30, accumulator Q.46
// Notes:   Purely combinational; the caller registers the sum
`timescale 1ns/1ps
`default_nettype none

module hpfq_mac (
  input  wire logic signed [hpfq_pkg::HPFQ_AW-1:0] acc_in,   // Running sum
  input  wire logic signed [hpfq_pkg::HPFQ_YW-1:0] operand,  // Sample or output
  input  wire logic signed [hpfq_pkg::HPFQ_CW-1:0] coef,     // Tap weight
  output logic      signed [hpfq_pkg::HPFQ_AW-1:0] acc_out   // Updated sum
);

  logic signed [hpfq_pkg::HPFQ_YW+hpfq_pkg::HPFQ_CW-1:0] prod;

  // Product is 68 bits; sign-extended into the 72-bit sum for headroom
  always_comb begin
    prod    = operand * coef;
    acc_out = acc_in + hpfq_pkg::HPFQ_AW'(prod);
  end

endmodule : hpfq_mac

`default_nettype wire

// ### test/hpfq_src.sv
// Purpose: Sample source standing in for the upstream audio feed
// Assumes: Changes only just after rising edges, holds until taken
// Notes:   Released sample lines carry the inverse of the last word
`timescale 1ns/1ps
`default_nettype none

module hpfq_src (
  input  wire logic        clk,     // Sample clock
  input  wire logic        ready,   // Filter can take a sample
  output var  logic        valid,   // Sample offered
  output var  logic [1:0]  rate,    // Rate code of the offer
  output var  logic [15:0] sample   // Offered sample
);
  initial begin
    valid  = 1'b0;
    rate   = 2'h0;
    sample = 16'h0;
  end

  // ----------------------------------------------------------------
  // Offer one sample, then idle for gap cycles (0 keeps valid up)
  // ----------------------------------------------------------------
  task automatic send(input logic [1:0] r, input logic [15:0] s,
                      input int gap);
    if (valid !== 1'b1) valid <= 1'b1;
    rate   <= r;
    sample <= s;
    do @(posedge clk); while (ready !== 1'b1);
    if (gap > 0) begin
      valid  <= 1'b0;
      sample <= ~s;  // A stale word must not pass for a fresh one
      repeat (gap) @(posedge clk);
    end
  endtask : send
endmodule : hpfq_src
`default_nettype wire

// ### test/hpfq_filter_tb_top.sv
// Purpose: Self-checking bench of the 20 Hz low-cut biquad
// Assumes: Bit-exact integer model of the hand-over arithmetic
// Notes:   Run is some 10000 cycles; watchdog allows about 50000
`timescale 1ns/1ps
`default_nettype none

module hpfq_filter_tb_top;
  logic               ref_clk;
  logic               rst;
  logic               in_ready;
  logic               out_valid;
  logic [15:0]        out_sample;
  logic               src_valid;
  logic [1:0]         src_rate;
  logic [15:0]        src_sample;
  int                 err_count;
  int                 checked;
  int                 cycle;
  int                 n_in;
  int                 n_out;
  logic [15:0]        last_out;
  logic signed [31:0] cf [16];
  logic signed [35:0] x1, x2, y1, y2;
  logic [15:0]        exp_q [$];
  int                 t_q [$];
  real kr [16] = '{0.988954248067140, -1.977908496134280, 1.977786483776764,
    -0.978030508491796, 0.994461788958195, -1.988923577916390,
    1.988892905899653, -0.988954249933127, 0.997227049904470,
    -1.994454099808940, 1.994446410541927, -0.994461789075954,
    0.998150511190452, -1.996301022380904, 1.996297601769122,
    -0.996304442992686};

  hpfq_filter dut_u (
    .REF_CLK            (ref_clk),
    .RST                (rst),
    .RATE_SEL           (src_rate),
    .IN_VALID           (src_valid),
    .IN_SAMPLE          (src_sample),
    .IN_READY           (in_ready),
    .OUT_VALID          (out_valid),
    .FILTERED_AUDIO_OUT (out_sample)
  );

  hpfq_src src_u (
    .clk    (ref_clk),
    .ready  (in_ready),
    .valid  (src_valid),
    .rate   (src_rate),
    .sample (src_sample)
  );

  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Reference model, run on every accept and every output
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin : mon
    logic signed [71:0] acc;
    logic signed [71:0] rnd;
    logic signed [35:0] x0;
    int                 k;
    cycle++;
    if (rst === 1'b1) begin
      {x1, x2, y1, y2} = '0;
      exp_q.delete();
      t_q.delete();
    end else begin
      if (out_valid === 1'b1) begin
        n_out++;
        last_out = out_sample;
        chk(exp_q.size() > 0, "output without input");
        if (exp_q.size() > 0) begin
          chk(out_sample === exp_q.pop_front(), "sample");
          chk(cycle - t_q.pop_front() == 7, "latency");
        end
      end
      if (src_valid === 1'b1 && in_ready === 1'b1) begin
        chk(exp_q.size() == 0, "taken while busy");
        n_in++;
        k = 4 * int'(src_rate);
        x0 = {{4{src_sample[15]}}, src_sample, 16'h0};
        acc = cf[k] * x0 + cf[k+1] * x1 + cf[k] * x2
            + cf[k+2] * y1 + cf[k+3] * y2;
        rnd = (acc + (72'sh1 <<< 45)) >>> 46;
        if (rnd > 72'sh7fff) exp_q.push_back(16'h7fff);
        else if (rnd < -72'sh8000) exp_q.push_back(16'h8000);
        else exp_q.push_back(rnd[15:0]);
        t_q.push_back(cycle);
        x2 = x1;
        x1 = x0;
        y2 = y1;
        y1 = acc[65:30];
      end
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Tests need some 10000 cycles; this cuts in near 50000
  initial begin : wdog
    #400000;
    err_count++;
    stop_test();
  end

  initial begin : main
    int          seed;
    logic [15:0] s;
    rst = 1'b1;
    seed = $urandom(17180);
    for (int i = 0; i < 16; i++) begin
      cf[i] = 32'($rtoi(kr[i] * 1073741824.0 + (kr[i] >= 0.0 ? 0.5 : -0.5)));
    end
    repeat (16) @(posedge ref_clk);
    chk(in_ready === 1'b1 && out_valid === 1'b0, "reset flags");
    chk(out_sample === 16'h0, "reset output");
    rst <= 1'b0;
    // Each rate, with full-scale jumps; history kept across rate change
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 40; i++) begin
        s = (i % 10 == 0) ? 16'h8000 : (i % 10 == 1) ? 16'h7fff
          : 16'($urandom);
        src_u.send(2'(r), s, i == 39 ? 8 : int'($urandom % 3));
      end
      $display("test rate %0d done", r);
    end
    // Back-to-back offers with a random rate code drawn for every sample
    for (int i = 0; i < 30; i++) begin
      src_u.send(2'($urandom), 16'($urandom), i == 29 ? 8 : 0);
    end
    $display("test rate switching done");
    // Held DC level must die away through the low cut; long enough
    // for a full-scale history left by the noise tests to decay too
    for (int i = 0; i < 1200; i++) begin
      src_u.send(2'h0, 16'h2710, i == 1199 ? 8 : 0);
    end
    chk($signed(last_out) < 100 && $signed(last_out) > -100, "dc");
    $display("test dc removal done");
    // Reset in mid-run clears the history
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(in_ready === 1'b1 && out_valid === 1'b0, "second reset");
    chk(out_sample === 16'h0, "second reset output");
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      src_u.send(2'h1, 16'($urandom), i == 9 ? 8 : 1);
    end
    chk(n_in == n_out, "one output per input");
    $display("test second reset done");
    stop_test();
  end
endmodule : hpfq_filter_tb_top
`default_nettype wire
